/* File: include/wdcu_defines.vh */
// constants for the watchdog control and unlock block
`ifndef WDCU_DEFINES_VH
`define WDCU_DEFINES_VH

// ==========================================================
// register addresses
`define WDCU_IO_CTRL 8'h21
`define WDCU_IO_CAUSE 8'h34
`define WDCU_DS_OFFSET 8'h20
`define WDCU_IO_TOP 8'h3F

// ==========================================================
// control register fields
`define WDCU_UNLOCK_BIT 4
`define WDCU_ON_BIT 3
`define WDCU_TSEL_HI 2
`define WDCU_TSEL_LO 0
`define WDCU_CTRL_RESET 8'h00

// ==========================================================
// reset cause register fields
`define WDCU_POR_BIT 0
`define WDCU_WDR_BIT 3

// ==========================================================
// timing
`define WDCU_UNLOCK_CYCLES 3'h4
`define WDCU_UNLOCK_LAST 3'h1
`define WDCU_BASE_PERIOD 16384
`define WDCU_CNT_W 22

// ==========================================================
// safety levels, one-hot
`define WDCU_LVL0 3'h1
`define WDCU_LVL1 3'h2
`define WDCU_LVL2 3'h4

`endif

/* File: src/wdcu_top.v */
// watchdog control register, timed unlock, timeout counter and reset cause flags
`timescale 1ns/1ps
`include "wdcu_defines.vh"

module wdcu_top #(
   parameter BASE_PERIOD = `WDCU_BASE_PERIOD
) (
   // clock and power-on reset
   input wire CLK_I,
   input wire RST_I,
   // register access bus
   input wire [7:0] ADDR_I,
   input wire DATA_SPACE_I,
   input wire WR_I,
   input wire RD_I,
   input wire [7:0] WDATA_I,
   output reg [7:0] RDATA_O,
   // core events
   input wire KICK_I,
   input wire CHIP_RST_I,
   // fuses and oscillator pins
   input wire LEGACY_COMPAT_FUSE_I,
   input wire ALWAYS_ON_FUSE_I,
   input wire WDT_OSC_I,
   // status
   output reg WDT_RESET_O,
   output wire WDT_ACTIVE_O
);

   reg [7:0] io_addr;
   reg sel_ctrl;
   reg sel_cause;
   reg [1:0] fuse_s1_q;
   reg [1:0] fuse_s2_q;
   reg osc_s1_q;
   reg osc_s2_q;
   reg osc_s3_q;
   wire osc_tick;
   reg [2:0] level;
   reg unlock_q;
   reg [2:0] unlock_cnt_q;
   reg on_q;
   reg [2:0] tsel_q;
   reg por_flag_q;
   reg wdr_flag_q;
   reg [`WDCU_CNT_W-1:0] cnt_q;
   wire [`WDCU_CNT_W-1:0] period_m1;
   wire [31:0] period_full;
   wire chip_rst;
   wire active;
   wire ctrl_wr;
   wire cause_wr;

   // ==========================================================
   // address decode
   // map data-space addresses of the low I/O range onto I/O offsets
   always @* begin
      io_addr = 8'h00;
      if (DATA_SPACE_I) begin
         io_addr = ADDR_I - `WDCU_DS_OFFSET;
      end else begin
         io_addr = ADDR_I;
      end
   end

   // registers decode only inside the directly reachable I/O range
   always @* begin
      sel_ctrl = 1'b0;
      sel_cause = 1'b0;
      if (DATA_SPACE_I && ADDR_I < `WDCU_DS_OFFSET) begin
         sel_ctrl = 1'b0;
      end else if (io_addr > `WDCU_IO_TOP) begin
         sel_ctrl = 1'b0;
      end else if (io_addr == `WDCU_IO_CTRL) begin
         sel_ctrl = 1'b1;
      end else if (io_addr == `WDCU_IO_CAUSE) begin
         sel_cause = 1'b1;
      end
   end

   assign ctrl_wr = WR_I & sel_ctrl;
   assign cause_wr = WR_I & sel_cause;

   // ==========================================================
   // pin synchronisers
   // fuses and oscillator pass two flip-flops before use
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         fuse_s1_q <= 2'h0;
         fuse_s2_q <= 2'h0;
         osc_s1_q <= 1'b0;
         osc_s2_q <= 1'b0;
         osc_s3_q <= 1'b0;
      end else begin
         fuse_s1_q <= {ALWAYS_ON_FUSE_I, LEGACY_COMPAT_FUSE_I};
         fuse_s2_q <= fuse_s1_q;
         osc_s1_q <= WDT_OSC_I;
         osc_s2_q <= osc_s1_q;
         osc_s3_q <= osc_s2_q;
      end
   end

   // one enable pulse per oscillator rising edge
   assign osc_tick = osc_s2_q & ~osc_s3_q;

   // safety level from the fuses
   always @* begin
      if (fuse_s2_q[1]) begin
         level = `WDCU_LVL2;
      end else if (fuse_s2_q[0]) begin
         level = `WDCU_LVL0;
      end else begin
         level = `WDCU_LVL1;
      end
   end

   // ==========================================================
   // control register
   assign chip_rst = CHIP_RST_I | WDT_RESET_O;
   // level 2 keeps the watchdog on regardless of the stored bit
   assign active = on_q | level[2];
   assign WDT_ACTIVE_O = active;

   // unlock window, on bit and timeout select
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         unlock_q <= 1'b0;
         unlock_cnt_q <= 3'h0;
         on_q <= 1'b0;
         tsel_q <= 3'h0;
      end else if (chip_rst) begin
         unlock_q <= 1'b0;
         unlock_cnt_q <= 3'h0;
         on_q <= 1'b0;
         tsel_q <= 3'h0;
      end else begin
         // unlock bit self-clears four clocks after a one is written
         if (ctrl_wr && WDATA_I[`WDCU_UNLOCK_BIT]) begin
            unlock_q <= 1'b1;
            unlock_cnt_q <= `WDCU_UNLOCK_CYCLES;
         end else if (unlock_cnt_q == `WDCU_UNLOCK_LAST) begin
            unlock_q <= 1'b0;
            unlock_cnt_q <= 3'h0;
         end else if (unlock_q) begin
            unlock_cnt_q <= unlock_cnt_q - 3'h1;
         end
         // a zero reaches the on bit only through the open window
         if (ctrl_wr && WDATA_I[`WDCU_ON_BIT]) begin
            on_q <= 1'b1;
         end else if (ctrl_wr && unlock_q && !level[2]) begin
            on_q <= 1'b0;
         end
         // timeout select free at level 0, guarded elsewhere
         if (ctrl_wr && (level[0] || unlock_q)) begin
            tsel_q <= WDATA_I[`WDCU_TSEL_HI:`WDCU_TSEL_LO];
         end
      end
   end

   // ==========================================================
   // timeout counter
   // full-width period, then cut to the counter width on purpose
   assign period_full = (BASE_PERIOD << tsel_q) - 32'h0000_0001;
   assign period_m1 = period_full[`WDCU_CNT_W-1:0];

   // counts oscillator ticks, restarts on kick, disable or chip reset
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cnt_q <= {`WDCU_CNT_W{1'b0}};
         WDT_RESET_O <= 1'b0;
      end else begin
         WDT_RESET_O <= 1'b0;
         if (chip_rst || KICK_I || !active) begin
            cnt_q <= {`WDCU_CNT_W{1'b0}};
         end else if (osc_tick) begin
            if (cnt_q >= period_m1) begin
               cnt_q <= {`WDCU_CNT_W{1'b0}};
               WDT_RESET_O <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // reset cause flags
   // only power-on resets them by hardware (por flag to one, wdr flag to zero); a set wins over a clear
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         por_flag_q <= 1'b1;
         wdr_flag_q <= 1'b0;
      end else begin
         if (cause_wr && !WDATA_I[`WDCU_POR_BIT]) begin
            por_flag_q <= 1'b0;
         end
         if (WDT_RESET_O) begin
            wdr_flag_q <= 1'b1;
         end else if (cause_wr && !WDATA_I[`WDCU_WDR_BIT]) begin
            wdr_flag_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // read data, registered one cycle after the read strobe
   always @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         RDATA_O <= `WDCU_CTRL_RESET;
      end else if (RD_I && sel_ctrl) begin
         RDATA_O <= {3'h0, unlock_q, active, tsel_q};
      end else if (RD_I && sel_cause) begin
         RDATA_O <= {4'h0, wdr_flag_q, 2'h0, por_flag_q};
      end else begin
         RDATA_O <= 8'h00;
      end
   end

endmodule

/* File: verification/wdcu_top_chk.sv */
// assertion checker for the watchdog control and unlock block
`timescale 1ns/1ps
module wdcu_chk #(parameter BASE_PERIOD = 4) (
   // clock, reset, bus, events, fuses, status
   input wire CLK_I, RST_I, DATA_SPACE_I, WR_I, RD_I, KICK_I, CHIP_RST_I, LEGACY_COMPAT_FUSE_I,
   input wire ALWAYS_ON_FUSE_I, WDT_OSC_I, WDT_RESET_O, WDT_ACTIVE_O,
   input wire [7:0] ADDR_I, WDATA_I, RDATA_O
);
   // ========
   // register decode; calm means no control reset this cycle
   wire ctl = ADDR_I == (DATA_SPACE_I ? 8'h41 : 8'h21);
   wire cau = ADDR_I == (DATA_SPACE_I ? 8'h54 : 8'h34);
   wire calm = !CHIP_RST_I && !WDT_RESET_O;
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   sequence opened; WR_I && ctl && WDATA_I[4] && calm; endsequence
   sequence rd_ctl; RD_I && ctl; endsequence
   // ========
   // assertions
   chk_pulse_one: assert property (WDT_RESET_O |=> !WDT_RESET_O) else $error("long pulse");
   chk_high_zero: assert property (RDATA_O[7:5] == 3'h0) else $error("high bits");
   chk_idle_zero: assert property (!RD_I |=> RDATA_O == 8'h00) else $error("data unasked");
   chk_unmapped_zero: assert property (RD_I && !ctl && !cau |=> RDATA_O == 8'h00) else $error("unmapped");
   chk_unlock_open: assert property (opened ##1 calm [*3] ##0 rd_ctl |=> RDATA_O[4]) else $error("shut");
   chk_unlock_close: assert property (opened ##1 (!(WR_I && WDATA_I[4])) [*5] ##0 rd_ctl |=> !RDATA_O[4])
      else $error("stuck open");
   chk_fuse_on: assert property (ALWAYS_ON_FUSE_I [*3] |-> WDT_ACTIVE_O) else $error("off");
   chk_flag_set: assert property (WDT_RESET_O ##1 ((!(WR_I && cau)) throughout (##[1:12] (RD_I && cau)))
      |=> RDATA_O[3]) else $error("no flag");
   chk_write_on: assert property (WR_I && ctl && WDATA_I[3] && calm |=> WDT_ACTIVE_O) else $error("not on");
endmodule
bind wdcu_top wdcu_chk #(.BASE_PERIOD(BASE_PERIOD)) u_chk (.CLK_I, .RST_I, .DATA_SPACE_I, .WR_I, .RD_I, .KICK_I,
   .CHIP_RST_I, .LEGACY_COMPAT_FUSE_I, .ALWAYS_ON_FUSE_I, .WDT_OSC_I, .WDT_RESET_O, .WDT_ACTIVE_O, .ADDR_I,
   .WDATA_I, .RDATA_O);

/* File: verification/wdcu_top_tb.sv */
// self-checking bench for the watchdog control and unlock block
`timescale 1ns/1ps
module wdcu_top_tb;
   logic CLK_I = 0, RST_I = 1, DATA_SPACE_I = 0, WR_I = 0, RD_I = 0, KICK_I = 0, CHIP_RST_I = 0;
   logic LEGACY_COMPAT_FUSE_I = 0, ALWAYS_ON_FUSE_I = 0, WDT_OSC_I = 0;
   logic [7:0] ADDR_I = 8'h00, WDATA_I = 8'h00;
   wire [7:0] RDATA_O;
   wire WDT_RESET_O, WDT_ACTIVE_O;
   int err_count = 0, tests_run = 0, pulses = 0;
   wdcu_top #(.BASE_PERIOD(4)) dut (.CLK_I, .RST_I, .ADDR_I, .DATA_SPACE_I, .WR_I, .RD_I, .WDATA_I, .RDATA_O,
      .KICK_I, .CHIP_RST_I, .LEGACY_COMPAT_FUSE_I, .ALWAYS_ON_FUSE_I, .WDT_OSC_I, .WDT_RESET_O, .WDT_ACTIVE_O);
   // ========
   // clock, reset pulse counter, hang guard at about three times the run
   initial forever #50 CLK_I = ~CLK_I;
   always @(negedge CLK_I) begin
      if (WDT_RESET_O === 1'b1) pulses++;
   end
   initial begin
      #5_000_000;
      err_count++;
      conclude();
   end
   task automatic conclude;
      if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [7:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   // ========
   // one bus cycle from falling edge to falling edge
   task automatic acc(input logic w, r, s, input logic [7:0] a, d);
      {WR_I, RD_I, DATA_SPACE_I, ADDR_I, WDATA_I} = {w, r, s, a, d};
      @(negedge CLK_I);
   endtask
   task automatic idle(input int n);
      repeat (n) acc(0, 0, 0, 8'h00, 8'h00);
   endtask
   task automatic wr(input logic [7:0] a, d);
      acc(1, 0, 0, a, d);
   endtask
   task automatic rd(input logic s, input logic [7:0] a, exp);
      acc(0, 1, s, a, 8'h00);
      cmp("read data", exp, RDATA_O);
   endtask
   // optional kick, then n slow oscillator periods of eight clocks
   task automatic tick(input logic k, input int n);
      KICK_I = k;
      idle(1);
      KICK_I = 0;
      repeat (2 * n) begin
         WDT_OSC_I = ~WDT_OSC_I;
         idle(4);
      end
   endtask
   // ========
   // scenarios
   initial begin
      repeat (8) @(negedge CLK_I);
      RST_I = 0;
      idle(2);
      rd(0, 8'h34, 8'h01);
      rd(1, 8'h54, 8'h01);
      rd(1, 8'h21, 8'h00);
      rd(0, 8'h30, 8'h00);
      CHIP_RST_I = 1;
      idle(1);
      CHIP_RST_I = 0;
      wr(8'h34, 8'hFF);
      rd(0, 8'h34, 8'h01);
      wr(8'h34, 8'h00);
      rd(0, 8'h34, 8'h00);
      wr(8'h21, 8'hEB);
      rd(0, 8'h21, 8'h08);
      wr(8'h21, 8'h18);
      idle(4);
      wr(8'h21, 8'h00);
      rd(0, 8'h21, 8'h08);
      wr(8'h21, 8'h18);
      wr(8'h21, 8'h03);
      rd(0, 8'h21, 8'h13);
      cmp("active", 8'h00, {7'h00, WDT_ACTIVE_O});
      idle(2);
      rd(1, 8'h41, 8'h03);
      // every timeout code: no reset after a kick and period less one, then one
      for (int t = 0; t < 8; t++) begin
         wr(8'h21, 8'h18);
         wr(8'h21, 8'h08 | 8'(t));
         idle(1);
         rd(0, 8'h21, 8'h18 | 8'(t));
         tick(1, (4 << t) - 1);
         tick(1, (4 << t) - 1);
         cmp("pulses", 8'(t), 8'(pulses));
         tick(0, 1);
         cmp("pulses", 8'(t + 1), 8'(pulses));
         rd(0, 8'h21, 8'h00);
         rd(0, 8'h34, 8'h08);
         wr(8'h34, 8'h00);
      end
      LEGACY_COMPAT_FUSE_I = 1;
      idle(3);
      acc(1, 0, 1, 8'h41, 8'h05);
      rd(0, 8'h21, 8'h05);
      ALWAYS_ON_FUSE_I = 1;
      idle(3);
      wr(8'h21, 8'h18);
      wr(8'h21, 8'h00);
      idle(4);
      rd(0, 8'h21, 8'h08);
      cmp("active", 8'h01, {7'h00, WDT_ACTIVE_O});
      tick(0, 4);
      cmp("pulses", 8'h09, 8'(pulses));
      conclude();
   end
endmodule
